// File: hdl/ots_top.sv
// Purpose: Output terminal source selection, logic and analogue modes
// Assumes: Measurements come from logic on aclk; registers over AXI4-Lite
// Notes: Analogue value is a 16-bit fraction of full scale;
//    bus ready pins are registered flags
// How it works
// - Setting 2 drives high while output frequency equals setpoint.
// - Setting 3 drives high while output frequency is above zero.
// - Setting 4 compares motor speed against the threshold pair.
// - Setting 5 compares motor current against the threshold pair.
// - Setting 6 compares motor torque against the threshold pair.
// - Setting 7 compares second analogue input against the pair.
// - Settings 4 to 7 set above upper, clear below lower or on a setting change.
// - Setting 8 scales output frequency, full scale at max speed.
// - Setting 9 scales current, full scale at twice rated current.
// - Setting 10 scales torque, full scale at twice rated torque.
// - Setting 11 scales power, full scale at 1.5 times rated power.
// - Setting 12 outputs the PID output over zero to hundred percent.
// - Setting 0 drives high while the drive is enabled and running.
// - Setting 1 drives high while no fault is present.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module ots_top (
   input wire logic aclk, // 100 MHz clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire ots_pkg::ots_meas_s meas, // Measured quantities
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   output logic term_logic, // Logic output level
   output logic [15:0] term_value, // Analogue output value
   output logic term_is_analog // High in modes 8 to 12
);
   // Whole module state
   typedef struct packed {
      // Software settings
      ots_pkg::ots_cfg_s cfg;
      // Comparator and terminal
      logic [3:0] prev_src;
      logic hyst;
      logic term_logic;
      logic [15:0] term_value;
      logic term_is_analog;
      // Write side
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      // Read side
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // Registered ready flags
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
   } ots_state_s;

   // State and its next value
   ots_state_s r;
   ots_state_s next_r;

   // Scaler hookup
   logic [15:0] scaled;
   logic [15:0] sc_value;
   logic [15:0] sc_rated;
   logic [7:0] sc_pct;

   // Merge a 16-bit field with byte strobes
   function automatic logic [15:0] ots_merge16(input logic [15:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      // Low byte lane
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      // High byte lane
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // Hysteresis step: set above upper, clear below lower
   function automatic logic ots_hyst(input logic cur, input logic [15:0] sig,
         input logic [15:0] up, input logic [15:0] lo);
      logic res;
      // Strict compares; inside the band it holds
      res = cur;
      if (sig > up) begin
         res = 1'b1;
      end else if (sig < lo) begin
         res = 1'b0;
      end
      return res;
   endfunction

   // Analogue source and full-scale pick
   always_comb begin
      // PID path unless a mode picks another
      sc_value = meas.pid;
      sc_rated = 16'd100;
      sc_pct = ots_pkg::PCT_PID_FS;
      // Source and rated value per mode
      case (r.cfg.output_source_select)
         ots_pkg::SRC_FREQ_OUT: begin
            sc_value = meas.out_freq;
            sc_rated = r.cfg.max_speed;
            sc_pct = 8'd100;
         end
         ots_pkg::SRC_CUR_OUT: begin
            sc_value = meas.current;
            sc_rated = r.cfg.rated_motor_current;
            sc_pct = ots_pkg::PCT_CUR_FS;
         end
         ots_pkg::SRC_TRQ_OUT: begin
            sc_value = meas.torque;
            sc_rated = r.cfg.rated_torque;
            sc_pct = ots_pkg::PCT_TRQ_FS;
         end
         ots_pkg::SRC_PWR_OUT: begin
            sc_value = meas.power;
            sc_rated = r.cfg.rated_power;
            sc_pct = ots_pkg::PCT_PWR_FS;
         end
         default: begin
            sc_value = meas.pid;
            sc_rated = 16'd100;
            sc_pct = ots_pkg::PCT_PID_FS;
         end
      endcase
   end

   // One scaler shared by all analogue modes
   ots_scale u_scale (
      .value(sc_value),
      .rated(sc_rated),
      .pct(sc_pct),
      .scaled(scaled)
   );

   // Next state: bus slave, register writes, terminal selection
   always_comb begin
      logic [15:0] sel_sig;
      logic [7:0] ra;
      sel_sig = 16'h0000;
      ra = s_axi_araddr;
      // Every register holds by default
      next_r = r;

      // Write channel capture, either order
      if (s_axi_awvalid && !r.aw_held && !r.bvalid) begin
         next_r.aw_held = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r.w_held && !r.bvalid) begin
         next_r.w_held = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      // Response taken frees the write side
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid = 1'b0;
      end

      // Perform write once both halves held
      if (r.aw_held && r.w_held && !r.bvalid) begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = ots_pkg::RESP_OKAY;
         // Decode by byte offset
         if (r.aw_addr == ots_pkg::OFF_SOURCE) begin
            // Source lives in byte lane 0
            if (r.w_strb[0]) begin
               next_r.cfg.output_source_select = r.w_data[3:0];
            end
         end else if (r.aw_addr == ots_pkg::OFF_UPPER) begin
            next_r.cfg.output_upper_threshold =
               ots_merge16(r.cfg.output_upper_threshold, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_LOWER) begin
            next_r.cfg.output_lower_threshold =
               ots_merge16(r.cfg.output_lower_threshold, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_MAX_SPEED) begin
            next_r.cfg.max_speed =
               ots_merge16(r.cfg.max_speed, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_RATED_CUR) begin
            next_r.cfg.rated_motor_current =
               ots_merge16(r.cfg.rated_motor_current, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_RATED_TRQ) begin
            next_r.cfg.rated_torque =
               ots_merge16(r.cfg.rated_torque, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_RATED_PWR) begin
            next_r.cfg.rated_power =
               ots_merge16(r.cfg.rated_power, r.w_data, r.w_strb);
         end else if (r.aw_addr == ots_pkg::OFF_STATUS ||
               r.aw_addr == ots_pkg::OFF_VALUE) begin
            next_r.bresp = ots_pkg::RESP_OKAY; // Read-only, write ignored
         end else begin
            next_r.bresp = ots_pkg::RESP_SLVERR;
         end
      end

      // Read channel
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid) begin
         next_r.rvalid = 1'b1;
         next_r.rresp = ots_pkg::RESP_OKAY;
         next_r.rdata = 32'h00000000;
         // Unmapped offsets answer with an error
         if (ra == ots_pkg::OFF_SOURCE) begin
            next_r.rdata = {28'h0000000, r.cfg.output_source_select};
         end else if (ra == ots_pkg::OFF_UPPER) begin
            next_r.rdata = {16'h0000, r.cfg.output_upper_threshold};
         end else if (ra == ots_pkg::OFF_LOWER) begin
            next_r.rdata = {16'h0000, r.cfg.output_lower_threshold};
         end else if (ra == ots_pkg::OFF_MAX_SPEED) begin
            next_r.rdata = {16'h0000, r.cfg.max_speed};
         end else if (ra == ots_pkg::OFF_RATED_CUR) begin
            next_r.rdata = {16'h0000, r.cfg.rated_motor_current};
         end else if (ra == ots_pkg::OFF_RATED_TRQ) begin
            next_r.rdata = {16'h0000, r.cfg.rated_torque};
         end else if (ra == ots_pkg::OFF_RATED_PWR) begin
            next_r.rdata = {16'h0000, r.cfg.rated_power};
         end else if (ra == ots_pkg::OFF_STATUS) begin
            next_r.rdata = {29'h0000000, r.term_is_analog, r.hyst,
               r.term_logic};
         end else if (ra == ots_pkg::OFF_VALUE) begin
            next_r.rdata = {16'h0000, r.term_value};
         end else begin
            next_r.rresp = ots_pkg::RESP_SLVERR;
         end
      end

      // Threshold signal for settings 4 to 7
      case (r.cfg.output_source_select)
         ots_pkg::SRC_SPEED_LIM: sel_sig = meas.out_freq;
         ots_pkg::SRC_CUR_LIM: sel_sig = meas.current;
         ots_pkg::SRC_TRQ_LIM: sel_sig = meas.torque;
         ots_pkg::SRC_AIN2_LIM: sel_sig = meas.ain2;
         default: sel_sig = 16'h0000;
      endcase

      // Hysteresis register, cleared on setting change
      next_r.prev_src = r.cfg.output_source_select;
      if (r.prev_src != r.cfg.output_source_select) begin
         next_r.hyst = 1'b0;
      end else if (r.cfg.output_source_select >= ots_pkg::SRC_SPEED_LIM &&
            r.cfg.output_source_select <= ots_pkg::SRC_AIN2_LIM) begin
         next_r.hyst = ots_hyst(r.hyst, sel_sig,
            r.cfg.output_upper_threshold,
            r.cfg.output_lower_threshold);
      end else begin
         // Other modes keep the comparator low
         next_r.hyst = 1'b0;
      end

      // Terminal output, logic or analogue
      next_r.term_logic = 1'b0;
      next_r.term_value = 16'h0000;
      next_r.term_is_analog = 1'b0;
      // Settings 0 to 3 are drive flags
      case (r.cfg.output_source_select)
         ots_pkg::SRC_RUNNING: next_r.term_logic = meas.running;
         ots_pkg::SRC_HEALTHY: next_r.term_logic = !meas.fault;
         ots_pkg::SRC_AT_TARGET:
            next_r.term_logic = meas.out_freq == meas.set_freq;
         ots_pkg::SRC_TURNING:
            next_r.term_logic = meas.out_freq != 16'h0000;
         ots_pkg::SRC_SPEED_LIM, ots_pkg::SRC_CUR_LIM,
         ots_pkg::SRC_TRQ_LIM, ots_pkg::SRC_AIN2_LIM:
            next_r.term_logic = next_r.hyst;
         ots_pkg::SRC_FREQ_OUT, ots_pkg::SRC_CUR_OUT, ots_pkg::SRC_TRQ_OUT,
         ots_pkg::SRC_PWR_OUT, ots_pkg::SRC_PID_OUT: begin
            next_r.term_is_analog = 1'b1;
            next_r.term_value = scaled;
         end
         // Settings 13 to 15 drive nothing
         default: next_r.term_logic = 1'b0;
      endcase

      // Ready flags for the coming cycle
      next_r.aw_rdy = !next_r.aw_held && !next_r.bvalid;
      next_r.w_rdy = !next_r.w_held && !next_r.bvalid;
      next_r.ar_rdy = !next_r.rvalid;
   end

   // State register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.cfg.output_source_select <= ots_pkg::RST_SOURCE;
         r.prev_src <= ots_pkg::RST_SOURCE;
         r.cfg.output_upper_threshold <= ots_pkg::RST_UPPER;
         r.cfg.output_lower_threshold <= ots_pkg::RST_LOWER;
         // Ratings start at one, so no zero divide
         r.cfg.max_speed <= ots_pkg::RST_MAX_SPEED;
         r.cfg.rated_motor_current <= ots_pkg::RST_RATED_CUR;
         r.cfg.rated_torque <= ots_pkg::RST_RATED_TRQ;
         r.cfg.rated_power <= ots_pkg::RST_RATED_PWR;
         // Channels free from the first edge
         r.aw_rdy <= 1'b1;
         r.w_rdy <= 1'b1;
         r.ar_rdy <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready = r.aw_rdy;
   assign s_axi_wready = r.w_rdy;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = r.ar_rdy;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   // Terminal pins
   assign term_logic = r.term_logic;
   assign term_value = r.term_value;
   assign term_is_analog = r.term_is_analog;
endmodule

// File: hdl/ots_pkg.sv
// Purpose: Shared constants and types for the output terminal source block
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz aclk
// Notes: Measured quantities are unsigned, one scale each
package ots_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_SOURCE = 8'h00;
   localparam logic [7:0] OFF_UPPER = 8'h04;
   localparam logic [7:0] OFF_LOWER = 8'h08;
   localparam logic [7:0] OFF_MAX_SPEED = 8'h0c;
   localparam logic [7:0] OFF_RATED_CUR = 8'h10;
   localparam logic [7:0] OFF_RATED_TRQ = 8'h14;
   localparam logic [7:0] OFF_RATED_PWR = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_VALUE = 8'h20;
   // Reset values
   localparam logic [3:0] RST_SOURCE = 4'h0;
   localparam logic [15:0] RST_UPPER = 16'h0000;
   localparam logic [15:0] RST_LOWER = 16'h0000;
   localparam logic [15:0] RST_MAX_SPEED = 16'h0001;
   localparam logic [15:0] RST_RATED_CUR = 16'h0001;
   localparam logic [15:0] RST_RATED_TRQ = 16'h0001;
   localparam logic [15:0] RST_RATED_PWR = 16'h0001;
   // Source settings
   localparam logic [3:0] SRC_RUNNING = 4'h0;
   localparam logic [3:0] SRC_HEALTHY = 4'h1;
   localparam logic [3:0] SRC_AT_TARGET = 4'h2;
   localparam logic [3:0] SRC_TURNING = 4'h3;
   localparam logic [3:0] SRC_SPEED_LIM = 4'h4;
   localparam logic [3:0] SRC_CUR_LIM = 4'h5;
   localparam logic [3:0] SRC_TRQ_LIM = 4'h6;
   localparam logic [3:0] SRC_AIN2_LIM = 4'h7;
   localparam logic [3:0] SRC_FREQ_OUT = 4'h8;
   localparam logic [3:0] SRC_CUR_OUT = 4'h9;
   localparam logic [3:0] SRC_TRQ_OUT = 4'ha;
   localparam logic [3:0] SRC_PWR_OUT = 4'hb;
   localparam logic [3:0] SRC_PID_OUT = 4'hc;
   // Full-scale multipliers in percent of the rated value
   localparam logic [7:0] PCT_CUR_FS = 8'd200;
   localparam logic [7:0] PCT_TRQ_FS = 8'd200;
   localparam logic [7:0] PCT_PWR_FS = 8'd150;
   localparam logic [7:0] PCT_PID_FS = 8'd100;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Measured quantities from the rest of the drive
   typedef struct packed {
      logic running;
      logic fault;
      logic [15:0] out_freq;
      logic [15:0] set_freq;
      logic [15:0] current;
      logic [15:0] torque;
      logic [15:0] power;
      logic [15:0] ain2;
      logic [15:0] pid;
   } ots_meas_s;

   // Software settings
   typedef struct packed {
      logic [3:0] output_source_select;
      logic [15:0] output_upper_threshold;
      logic [15:0] output_lower_threshold;
      logic [15:0] max_speed;
      logic [15:0] rated_motor_current;
      logic [15:0] rated_torque;
      logic [15:0] rated_power;
   } ots_cfg_s;
endpackage

// File: hdl/ots_scale.sv
// Purpose: Scale a quantity to a 16-bit full-range value
// Assumes: Inputs hold steady for one cycle; combinational result
// Notes: Full scale is rated times pct over 100; saturates above it
`timescale 1ns/1ns
module ots_scale (
   input wire logic [15:0] value, // Quantity to scale
   input wire logic [15:0] rated, // Rated reference
   input wire logic [7:0] pct, // Full scale in percent of rated
   output logic [15:0] scaled // 0 to ffff of full scale
);
   logic [23:0] full;
   logic [39:0] num;
   logic [39:0] quo;

   // Full scale and linear ratio with saturation
   always_comb begin
      full = (24'(rated) * 24'(pct)) / 24'd100;
      if (full == 24'h000000) begin
         full = 24'h000001;
      end
      num = 40'({value, 16'h0000}) - 40'(value);
      quo = num / 40'(full);
      if (quo > 40'h000000ffff) begin
         scaled = 16'hffff;
      end else begin
         scaled = quo[15:0];
      end
   end
endmodule

// File: testbench/ots_top_assertions.sv
// Purpose: Port-level checks of the output terminal block
// Assumes: A source write lands only with strobe bit 0 set
// Notes: Shadows the source setting from completed writes
`timescale 1ns/1ns
module ots_chk (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire ots_pkg::ots_meas_s meas, // Measurements
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Address valid
   input wire logic s_axi_awready, // Address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Strobes
   input wire logic s_axi_wvalid, // Data valid
   input wire logic s_axi_wready, // Data ready
   input wire logic [1:0] s_axi_bresp, // Response
   input wire logic s_axi_bvalid, // Response valid
   input wire logic s_axi_bready, // Response ready
   input wire logic s_axi_arvalid, // Read valid
   input wire logic s_axi_arready, // Read ready
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic term_logic, // Logic level
   input wire logic [15:0] term_value, // Analogue value
   input wire logic term_is_analog // Analogue mode
);
   logic [7:0] a_q;
   logic [3:0] d_q;
   logic s_q;
   logic [3:0] src_q;
   logic calm;
   logic quiet;
   // No write settling, so the shadow matches the design
   assign quiet = calm && !s_axi_bvalid;
   // Shadow of the source setting
   always_ff @(posedge aclk) begin
      calm <= aresetn && !s_axi_bvalid;
      if (!aresetn) begin
         src_q <= 4'h0;
      end else if (s_axi_bvalid && s_axi_bready && a_q == 8'h00 &&
            s_axi_bresp == 2'b00 && s_q) begin
         src_q <= d_q;
      end
      if (s_axi_awvalid && s_axi_awready)
         a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
         d_q <= s_axi_wdata[3:0];
         s_q <= s_axi_wstrb[0];
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_RESET_IDLE: assert property (disable iff (1'b0)
      !aresetn |=> !term_logic && !term_is_analog && term_value == 16'h0)
      else $error("outputs not idle in reset");
   AST_RUN_FLAG: assert property (
      quiet && src_q == 4'h0 |=> term_logic == $past(meas.running))
      else $error("running flag wrong");
   AST_HEALTHY: assert property (
      quiet && src_q == 4'h1 |=> term_logic == !$past(meas.fault))
      else $error("healthy flag wrong");
   AST_AT_TARGET: assert property (
      quiet && src_q == 4'h2 && meas.out_freq == meas.set_freq
      |=> term_logic) else $error("at target flag wrong");
   AST_TURNING: assert property (
      quiet && src_q == 4'h3 |=> term_logic == ($past(meas.out_freq) != 0))
      else $error("turning flag wrong");
   AST_MODE_KIND: assert property (
      quiet |=> term_is_analog == ($past(src_q) inside {[4'h8:4'hc]}))
      else $error("mode kind wrong");
   AST_PID_SCALE: assert property (
      quiet && src_q == 4'hc && meas.pid <= 16'd100 |=>
      term_value == 16'(32'($past(meas.pid)) * 65535 / 100))
      else $error("pid value wrong");
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   AST_WRITE_BUSY: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write not held");
endmodule

// File: testbench/ots_indicator.sv
// Purpose: Meter reading the output terminal once a cycle
// Assumes: Terminal outputs are registered on aclk
// Notes: Adds one cycle of delay, as a real reader would
`timescale 1ns/1ns
module ots_indicator (
   input wire logic aclk, // Clock
   input wire logic level, // Logic output
   input wire logic [15:0] value, // Analogue value
   input wire logic analog, // Analogue mode
   output logic seen_level, // Latched level
   output logic [15:0] seen_value, // Latched value
   output logic seen_analog // Latched mode
);
   // Sample the terminal
   always_ff @(posedge aclk) begin
      seen_level <= level;
      seen_value <= value;
      seen_analog <= analog;
   end
endmodule

// File: testbench/tb_ots_top.sv
// Purpose: Self-checking bench for the output terminal block
// Assumes: One write and one read at a time on the register bus
// Notes: Model mirrors settings and hysteresis with integers
`timescale 1ns/1ns
module tb_ots_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   ots_pkg::ots_meas_s meas = '0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic awr, wr_r, bv, arr, rv, t_lg, t_an, s_lg, s_an;
   logic [1:0] bresp, rresp;
   logic [15:0] t_val, s_val, rnd = 16'h0024;
   int n_fail = 0, n_compared = 0, m_hyst = 0, i, j;
   int cfg[7] = '{0, 1000, 500, 1000, 100, 100, 200};
   int rst[7] = '{0, 0, 0, 1, 1, 1, 1};
   int hv[8] = '{600, 1001, 700, 499, 1000, 1500, 500, 501};
   // Clock
   always #5 aclk = ~aclk;
   ots_top dut (.aclk(aclk), .aresetn(aresetn), .meas(meas),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rready), .term_logic(t_lg),
      .term_value(t_val), .term_is_analog(t_an));
   ots_indicator ind (.aclk(aclk), .level(t_lg), .value(t_val),
      .analog(t_an), .seen_level(s_lg), .seen_value(s_val),
      .seen_analog(s_an));
   // Verdict and end of run
   task automatic give_verdict;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_bit(input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // Bus write; waits for the response under a bound
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] st, input logic [1:0] er);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50 && !(k > 0 && bv); k++) begin
         @(posedge aclk);
         if (awr)
            awv <= 1'b0;
         if (wr_r)
            wv <= 1'b0;
      end
      if (!bv) begin
         n_fail++;
         give_verdict();
      end
      bready <= 1'b0;
      cmp_word({30'h0, er}, {30'h0, bresp});
   endtask
   // Bus read with comparison of data and response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      int k;
      @(posedge aclk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50 && !(k > 0 && rv); k++) begin
         @(posedge aclk);
         if (arr)
            arv <= 1'b0;
      end
      if (!rv) begin
         n_fail++;
         give_verdict();
      end
      rready <= 1'b0;
      cmp_word({30'h0, er}, {30'h0, rresp});
      if (er == 2'b00)
         cmp_word(ed, rdata);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic longint scl(input longint v, input longint full);
      longint r;
      r = v * 65535 / full;
      return (r > 65535) ? 65535 : r;
   endfunction
   // Change the source; model clears the comparator state
   task automatic set_src(input int s);
      meas <= {2'b00, {7{16'd700}}}; // Mid-band, shows a missed clear
      wr(8'h00, 32'(s), 4'hf, 2'b00);
      m_hyst = 0;
      repeat (3) @(posedge aclk);
   endtask
   // Apply one set of measurements and compare against the model
   task automatic step(input int src, input ots_pkg::ots_meas_s m);
      int sig;
      logic lg;
      longint v;
      @(posedge aclk);
      meas <= m;
      repeat (4) @(posedge aclk);
      sig = (src == 4) ? m.out_freq : (src == 5) ? m.current :
         (src == 6) ? m.torque : m.ain2;
      if (src > 3 && src < 8 && sig > cfg[1])
         m_hyst = 1;
      else if (src > 3 && src < 8 && sig < cfg[2])
         m_hyst = 0;
      lg = (src == 0) ? m.running : (src == 1) ? !m.fault :
         (src == 2) ? (m.out_freq == m.set_freq) :
         (src == 3) ? (m.out_freq != 0) : (src < 8) && m_hyst[0];
      v = (src == 8) ? scl(m.out_freq, cfg[3]) :
         (src == 9) ? scl(m.current, 2 * cfg[4]) :
         (src == 10) ? scl(m.torque, 2 * cfg[5]) :
         (src == 11) ? scl(m.power, 3 * cfg[6] / 2) :
         (src == 12) ? scl(m.pid, 100) : 0;
      cmp_bit(src > 7 && src < 13, s_an);
      if (src < 8 || src > 12)
         cmp_bit(lg, s_lg);
      if (src > 7)
         cmp_word(32'(v), {16'h0, s_val});
      if (src > 7)
         rd_chk(8'h20, 32'(v), 2'b00);
      rd_chk(8'h1c, 32'({src > 7 && src < 13,
         src > 3 && src < 8 && m_hyst[0], lg}), 2'b00);
   endtask
   // Random measurements, or all ones to force saturation
   task automatic rand_step(input int src, input bit sat);
      ots_pkg::ots_meas_s m;
      int k;
      for (k = 0; k < 7; k++) begin
         rnd = lfsr(rnd);
         m[16 * k +: 16] = rnd & 16'h00ff;
      end
      m.running = rnd[9];
      m.fault = rnd[10];
      if (rnd[11])
         m.out_freq = 16'h0;
      if (rnd[12])
         m.set_freq = m.out_freq;
      if (sat)
         m = '1;
      step(src, m);
   endtask
   // Main sequence
   initial begin
      ots_pkg::ots_meas_s m;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 7; i++)
         rd_chk(8'(4 * i), rst[i], 2'b00);
      rd_chk(8'h24, 32'h0, 2'b10);
      wr(8'h24, 32'h1, 4'hf, 2'b10);
      wr(8'h1c, 32'h7, 4'hf, 2'b00);
      wr(8'h00, 32'h5, 4'he, 2'b00);
      for (i = 1; i < 7; i++)
         wr(8'(4 * i), cfg[i], 4'hf, 2'b00);
      for (i = 0; i < 7; i++)
         rd_chk(8'(4 * i), cfg[i], 2'b00);
      for (i = 0; i < 14; i++) begin
         set_src(i);
         if (i > 3 && i < 8) begin
            for (j = 0; j < 8; j++) begin
               m = '0;
               case (i)
                  4: m.out_freq = 16'(hv[j]);
                  5: m.current = 16'(hv[j]);
                  6: m.torque = 16'(hv[j]);
                  default: m.ain2 = 16'(hv[j]);
               endcase
               step(i, m);
            end
         end
         repeat (6) rand_step(i, 1'b0);
         rand_step(i, 1'b1);
      end
      give_verdict();
   end
endmodule
bind ots_top ots_chk chk (.aclk(aclk), .aresetn(aresetn), .meas(meas),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .term_logic(term_logic),
   .term_value(term_value), .term_is_analog(term_is_analog));
